// ==== logic/io_power_config_sequencer.sv ====
// i/o pin state sequencer across power-on, configuration, start-up and user mode
// assumes power-good, straps and done indication are synchronous to i_sys_clk
//
// Behaviour
// - wait for core, aux, bank-2 power-good
// - outputs high impedance before configuration
// - low strap enables pull-ups until configured
// - unconnected pull-up strap reads high
// - init memory and assert global set-reset
// - init done: raise init, sample mode straps
// - outputs stay high impedance during configuration
// - release global set-reset at configuration end
// - release tristate, idle pins take the selected termination
// - idle pin termination from i_idle_pin_termination, sampled at configuration end
// - write enable released one cycle later
// - user mode: pull-ups to user, strap freed
// - pull-downs active during boundary-scan extest/highz
// - same behaviour for input-only, unused dual-purpose
`default_nettype none
module io_power_config_sequencer
    import io_power_config_pkg::*;
#(
    parameter int INIT_CYCLES = INIT_CYCLES_DEF
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_vccint_good,
    input  wire logic       i_vccaux_good,
    input  wire logic       i_vcco_bank2_good,
    input  wire logic       i_pullup_disable_strap,
    input  wire logic       i_pullup_strap_driven,
    input  wire logic       i_mode_strap_0,
    input  wire logic       i_mode_strap_1,
    input  wire logic       i_mode_strap_2,
    input  wire logic       i_config_done,
    input  wire logic [1:0] i_idle_pin_termination,
    input  wire logic       i_boundary_scan_hiz,
    output logic            o_init_done_n,
    output logic [2:0]      o_config_mode,
    output logic            o_global_set_reset_net,
    output logic            o_global_tristate_net,
    output logic            o_global_write_enable_net,
    output logic            o_config_pullup_en,
    output logic            o_idle_pullup_en,
    output logic            o_idle_pulldown_en,
    output logic            o_user_mode,
    output logic            o_strap_pin_free
);
    //----------------------------------------------------------------
    // parameter check
    //----------------------------------------------------------------
    localparam int CNT_W = $clog2(INIT_CYCLES + 1);
    // a zero-length initialisation would leave the counter compare unreachable
    if (INIT_CYCLES < 1) begin : g_bad_init_cycles
        $error("INIT_CYCLES must be at least 1");
    end

    //----------------------------------------------------------------
    // state
    //----------------------------------------------------------------
    seq_state_type      state;
    seq_state_type      next_state;
    logic [CNT_W-1:0]   init_cnt;
    logic [CNT_W-1:0]   next_init_cnt;
    logic [2:0]         mode;
    logic [2:0]         next_mode;
    logic [1:0]         term;
    logic [1:0]         next_term;
    logic               init_n;
    logic               next_init_n;
    logic               power_good;
    logic               strap_level;

    // power is good only while all three rails report good
    assign power_good  = i_vccint_good & i_vccaux_good & i_vcco_bank2_good;
    // internal pull-up: an undriven strap reads high
    assign strap_level = i_pullup_strap_driven ? i_pullup_disable_strap : 1'b1;

    // next-state logic of the sequencer
    always_comb begin
        next_state    = state;
        next_init_cnt = init_cnt;
        next_mode     = mode;
        next_term     = term;
        next_init_n   = init_n;
        case (state)
            ST_POWER_WAIT: begin
                next_init_cnt = '0;
                if (power_good) begin
                    next_state = ST_INIT_MEM;
                end
            end
            ST_INIT_MEM: begin
                next_init_cnt = init_cnt + CNT_W'(1);
                if (init_cnt == CNT_W'(INIT_CYCLES - 1)) begin
                    next_init_n = 1'b1;
                    next_mode   = {i_mode_strap_2, i_mode_strap_1, i_mode_strap_0};
                    next_state  = ST_CONFIG;
                end
            end
            ST_CONFIG: begin
                if (i_config_done) begin
                    next_term  = i_idle_pin_termination;
                    next_state = ST_RELEASE_TRI;
                end
            end
            ST_RELEASE_TRI: begin
                next_state = ST_RELEASE_WE;
            end
            ST_RELEASE_WE: begin
                next_state = ST_USER;
            end
            ST_USER: begin
                next_state = ST_USER;
            end
            default: begin
                next_state = ST_POWER_WAIT;
            end
        endcase
        if (!power_good) begin
            next_state = ST_POWER_WAIT;
            next_init_n = 1'b0;
        end
    end

    // registers of the sequencer
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            state    <= ST_POWER_WAIT;
            init_cnt <= '0;
            mode     <= MODE_RESET_VALUE;
            term     <= TERM_RESET_VALUE;
            init_n   <= 1'b0;
        end else begin
            state    <= next_state;
            init_cnt <= next_init_cnt;
            mode     <= next_mode;
            term     <= next_term;
            init_n   <= next_init_n;
        end
    end

    //----------------------------------------------------------------
    // pin controls, each a registered single-bit step
    //----------------------------------------------------------------
    logic global_set_reset_net;
    logic global_tristate_net;
    logic global_write_enable_net;
    logic cfg_pu;
    logic idle_pu;
    logic idle_pd;
    logic user;
    logic next_gsr;
    logic next_gts;
    logic next_gwe;
    logic next_cfg_pu;
    logic next_idle_pu;
    logic next_idle_pd;
    logic next_user;
    logic pre_user;

    // derive pin controls from the phase the sequencer is entering
    always_comb begin
        pre_user     = (next_state == ST_RELEASE_WE) || (next_state == ST_USER);
        // global set-reset held until configuration ends
        next_gsr     = (next_state == ST_POWER_WAIT) || (next_state == ST_INIT_MEM)
                       || (next_state == ST_CONFIG);
        // tristate held through power-up and configuration
        next_gts     = !pre_user;
        // write enable one cycle after the tristate release
        next_gwe     = (next_state == ST_USER);
        next_user    = pre_user;
        // strap pull-ups only before user mode
        next_cfg_pu  = !pre_user && !strap_level;
        next_idle_pu = pre_user && (term == TERM_PULLUP);
        next_idle_pd = pre_user && (term == TERM_PULLDOWN);
        // boundary scan overrides the idle termination in every phase
        // so the pull-down is on whatever the sequencer is doing
        if (i_boundary_scan_hiz) begin
            next_idle_pd = 1'b1;
            next_idle_pu = 1'b0;
        end
    end

    // registers of the pin controls
    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            global_set_reset_net     <= 1'b1;
            global_tristate_net     <= 1'b1;
            global_write_enable_net     <= 1'b0;
            cfg_pu  <= 1'b0;
            idle_pu <= 1'b0;
            idle_pd <= 1'b0;
            user    <= 1'b0;
        end else begin
            global_set_reset_net     <= next_gsr;
            global_tristate_net     <= next_gts;
            global_write_enable_net     <= next_gwe;
            cfg_pu  <= next_cfg_pu;
            idle_pu <= next_idle_pu;
            idle_pd <= next_idle_pd;
            user    <= next_user;
        end
    end

    //----------------------------------------------------------------
    // outputs
    //----------------------------------------------------------------
    assign o_init_done_n             = init_n;
    assign o_config_mode             = mode;
    assign o_global_set_reset_net    = global_set_reset_net;
    assign o_global_tristate_net     = global_tristate_net;
    assign o_global_write_enable_net = global_write_enable_net;
    assign o_config_pullup_en        = cfg_pu;
    assign o_idle_pullup_en          = idle_pu;
    assign o_idle_pulldown_en        = idle_pd;
    assign o_user_mode               = user;
    assign o_strap_pin_free          = user;
endmodule
`default_nettype wire

// ==== logic/io_power_config_pkg.sv ====
// constants for the i/o power-on and configuration sequencer
// assumes a single 100 MHz system clock and a synchronous active-low reset
`default_nettype none
package io_power_config_pkg;
    // idle pin termination choices after the tristate release
    localparam logic [1:0] TERM_PULLDOWN      = 2'h0;
    localparam logic [1:0] TERM_PULLUP        = 2'h1;
    localparam logic [1:0] TERM_FLOAT         = 2'h2;
    localparam logic [1:0] TERM_RESET_VALUE   = TERM_PULLDOWN;
    // cycles from tristate release to write-enable release
    localparam int         WE_DELAY_CYCLES    = 1;
    // default length of configuration memory initialisation, in cycles
    localparam int         INIT_CYCLES_DEF    = 16;
    // mode strap value held after reset, before sampling
    localparam logic [2:0] MODE_RESET_VALUE   = 3'h0;
    // sequencer phases
    typedef enum logic [2:0] {
        ST_POWER_WAIT,
        ST_INIT_MEM,
        ST_CONFIG,
        ST_RELEASE_TRI,
        ST_RELEASE_WE,
        ST_USER
    } seq_state_type;
endpackage
`default_nettype wire

// ==== sim/io_power_config_sequencer_monitor.sv ====
// port-level timing checks for the i/o power and configuration sequencer
// assumes it is bound into every io_power_config_sequencer instance
`default_nettype none
module io_power_config_sequencer_monitor #(parameter int INIT_CYCLES = 16) (
    input wire logic i_sys_clk, i_rst_n, i_vccint_good, i_vccaux_good, i_vcco_bank2_good,
    input wire logic i_pullup_disable_strap, i_pullup_strap_driven, i_boundary_scan_hiz,
    input wire logic i_mode_strap_0, i_mode_strap_1, i_mode_strap_2,
    input wire logic o_init_done_n, o_global_set_reset_net, o_global_tristate_net,
    input wire logic o_global_write_enable_net, o_config_pullup_en, o_idle_pullup_en,
    input wire logic o_idle_pulldown_en, o_user_mode, o_strap_pin_free,
    input wire logic [2:0] o_config_mode
);
    timeunit 1ns;
    timeprecision 1ns;
    wire logic pg = i_vccint_good & i_vccaux_good & i_vcco_bank2_good;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // -----------------------------------------------
    // sequencing checks
    // -----------------------------------------------
    AST_POWER_GATE: assert property (
        !pg |=> o_global_set_reset_net && o_global_tristate_net
            && !o_global_write_enable_net && !o_init_done_n) else $error("power loss not held");
    AST_INIT_HIZ: assert property (
        !o_init_done_n |-> o_global_set_reset_net && o_global_tristate_net)
        else $error("drivers or set-reset released during init");
    AST_CFG_HIZ: assert property (
        !o_user_mode |-> o_global_tristate_net && !o_global_write_enable_net)
        else $error("drivers active before user mode");
    AST_SET_RESET_FIRST: assert property (
        $fell(o_global_tristate_net) |-> !$past(o_global_set_reset_net) && o_user_mode)
        else $error("tristate released before set-reset");
    AST_WE_DELAY: assert property (
        $fell(o_global_tristate_net) |=> $rose(o_global_write_enable_net))
        else $error("write enable not one cycle after tristate release");
    AST_INIT_LEN: assert property (
        $rose(pg) |-> ##INIT_CYCLES !o_init_done_n ##1 o_init_done_n)
        else $error("init length wrong");
    AST_MODE_SAMPLE: assert property (
        $rose(o_init_done_n) |-> o_config_mode ==
            $past({i_mode_strap_2, i_mode_strap_1, i_mode_strap_0})) else $error("mode bad");
    AST_PULLUP: assert property (
        $past(i_rst_n) && !o_user_mode |-> o_config_pullup_en ==
            !($past(i_pullup_disable_strap) || !$past(i_pullup_strap_driven)))
        else $error("config pull-up does not follow strap");
    AST_USER_FREE: assert property (
        o_user_mode |-> o_strap_pin_free && !o_config_pullup_en) else $error("strap not freed");
    AST_SCAN_PD: assert property (
        $past(i_boundary_scan_hiz) && $past(i_rst_n) |-> o_idle_pulldown_en && !o_idle_pullup_en)
        else $error("pull-down not active in scan");
    cover property ($rose(o_user_mode));
    cover property ($rose(o_global_write_enable_net));
    cover property ($fell(o_init_done_n) && o_config_mode != 3'h0);
endmodule
bind io_power_config_sequencer io_power_config_sequencer_monitor
    #(.INIT_CYCLES(INIT_CYCLES)) io_power_config_sequencer_monitor_inst (.*);
`default_nettype wire

// ==== sim/board_supply_model.sv ====
// board supplies: three rails whose power-good flags settle at different times
// assumes the bench switches rails on and off between clock edges
`default_nettype none
module board_supply_model (
    input  wire logic       i_sys_clk,
    input  wire logic [2:0] i_rail_on,
    output logic      [2:0] o_good
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] d1 = 3'h0;
    logic [2:0] d2 = 3'h0;
    // rails settle after 0, 1 and 2 cycles, any rail drops at once
    always @(posedge i_sys_clk) begin
        d1 <= i_rail_on;
        d2 <= d1 & i_rail_on;
    end
    assign o_good = {d2[2], d1[1], 1'b1} & i_rail_on;
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench: every change of the sequencer outputs except the strap pull-up and strap-free flags is matched to a note
// assumes INIT_CYCLES shortened to 2 and the board supply model on the power-good inputs
`default_nettype none
module testbench;
    import io_power_config_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, strap = 1'b1, driven = 1'b1, done = 1'b0, scan = 1'b0;
    logic [2:0] rail = 3'h0, mode = 3'h0, good, cmode;
    logic [1:0] term = 2'h0;
    logic [31:0] rng = 32'h00012df0;
    logic init_n, set_rst, tri_hold, wr_en, ipu, ipd, user, cfg_pu, pin_free;
    logic [9:0] last = 10'h180, phase = 10'h180, seen, notes[$];
    int failures = 0, n_compared = 0;
    board_supply_model board_supply_model_inst (.i_sys_clk(clk), .i_rail_on(rail), .o_good(good));
    io_power_config_sequencer #(.INIT_CYCLES(2)) io_power_config_sequencer_inst (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_vccint_good(good[0]), .i_vccaux_good(good[1]),
        .i_vcco_bank2_good(good[2]), .i_pullup_disable_strap(strap),
        .i_pullup_strap_driven(driven), .i_mode_strap_0(mode[0]), .i_mode_strap_1(mode[1]),
        .i_mode_strap_2(mode[2]), .i_config_done(done), .i_idle_pin_termination(term),
        .i_boundary_scan_hiz(scan), .o_init_done_n(init_n), .o_config_mode(cmode),
        .o_global_set_reset_net(set_rst), .o_global_tristate_net(tri_hold),
        .o_global_write_enable_net(wr_en), .o_config_pullup_en(cfg_pu), .o_idle_pullup_en(ipu),
        .o_idle_pulldown_en(ipd), .o_user_mode(user), .o_strap_pin_free(pin_free));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v = v ^ (v << 13);
        v = v ^ (v >> 17);
        return v ^ (v << 5);
    endfunction
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results;
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // idle cycles with the pull-up strap and its driven flag wandering
    task automatic cyc(input int n);
        repeat (n) begin
            @(negedge clk);
            rng = xs(rng);
            strap = rng[0];
            driven = rng[1];
        end
    endtask
    initial forever #5 clk = ~clk;
    initial begin
        #50us;
        $display("wrong value at %0t: timeout", $time);
        failures++;
        results();
    end
    // every output change except the strap pull-up and strap-free flags takes the oldest note; a change with no note is a mismatch
    always @(posedge clk) begin
        #1;
        seen = {init_n, set_rst, tri_hold, wr_en, user, ipd, ipu, cmode};
        if (seen !== last) begin
            phase = notes.size() ? notes.pop_front() : ~seen;
            check(seen, phase);
            last = seen;
        end
        // strap pull-ups follow the strap outside user mode, strap pin freed in user mode
        check(10'({cfg_pu, pin_free}),
              10'({rst_n && !phase[5] && driven && !strap, phase[5]}));
    end
    // one power-up per termination code, the first with a power loss in configuration
    initial begin
        cyc(16);
        rst_n = 1'b1;
        for (int r = 0; r < 4; r++) begin
            term = r[1:0];
            rail = 3'h3;
            cyc(8);
            rng = xs(rng);
            mode = rng[4:2];
            rail = 3'h7;
            notes.push_back({7'b1110000, mode});
            cyc(10);
            if (r == 0) begin
                rail = 3'h6;
                notes.push_back({7'b0110000, mode});
                cyc(4);
                mode = ~mode;
                rail = 3'h7;
                notes.push_back({7'b1110000, mode});
                cyc(10);
            end
            done = 1'b1;
            notes.push_back({7'b1010000, mode});
            notes.push_back({5'b10001, term == 2'h0, term == 2'h1, mode});
            notes.push_back({5'b10011, term == 2'h0, term == 2'h1, mode});
            cyc(1);
            done = 1'b0;
            cyc(5);
            scan = 1'b1;
            if (term != 2'h0) begin
                notes.push_back({7'b1001110, mode});
                notes.push_back({5'b10011, 1'b0, term == 2'h1, mode});
            end
            cyc(1);
            scan = 1'b0;
            cyc(5);
            rst_n = 1'b0;
            rail = 3'h0;
            notes.push_back(10'h180);
            cyc(3);
            rst_n = 1'b1;
        end
        cyc(5);
        check(10'(notes.size()), 10'h0);
        results();
    end
endmodule
`default_nettype wire
